// ---- rtl/pin_driver.sv ----
// one interrupt pin: edge or level shaping, polarity, drive type
// assumes the request is synchronous to hclk
`timescale 1ns/100ps
`default_nettype none
`include "pin_irq_cfg.svh"
module pin_driver
  import pin_irq_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // configuration
  input wire logic drive_enable,
  input wire logic open_drain,
  input wire logic polarity,
  input wire logic edge_select,
  // combined request from enabled, routed sources
  input wire logic request,
  // pin signals, output enable low while driven
  output logic pin_out,
  output logic pin_oe_n
);
  pin_stage_t state;
  pin_stage_t next_state;
  logic asserted;
  // edge mode only counts while the driver is on
  always_comb begin
    next_state = state;
    next_state.active_prev = request;
    next_state.pulse = request & ~state.active_prev;
    asserted = (drive_enable & edge_select) ? next_state.pulse
                                            : request;
    next_state.pin_level = asserted ~^ polarity;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  // open drain releases the pin for the high level
  always_comb begin
    pin_out = state.pin_level;
    if (!drive_enable) begin
      pin_oe_n = 1'b1;
    end else if (open_drain) begin
      pin_oe_n = state.pin_level;
    end else begin
      pin_oe_n = 1'b0;
    end
  end
endmodule // pin_driver
`default_nettype wire

// ---- rtl/pin_irq_ctrl.sv ----
// interrupt engine and pin control, registers over ahb-lite
// assumes fifo and data path give synchronous levels on hclk
// Notes on behaviour
// - enable bits 6,5,4: watermark, full, ready
// - bit 7 turns second pin driver on
// - bit 6 second pin open drain
// - bit 5 second pin polarity, output or trigger
// - frame tagging ignores pin polarity
// - bit 4 second pin edge mode
// - bit 3 turns first pin driver on
// - bit 2 first pin open drain
// - bit 1 first pin polarity, output or trigger
// - bit 0 first pin edge mode
// - edge mode only while driver enabled
// - input enables bits 5,4, rest reserved
// - routing bits 7,6,5 go to first pin
// - routing bits 3,2,1 go to second pin
// - routing one is active, zero inactive
// - external mapping on either pin disables all routing to both pins
// - watermark fires when fill exceeds it, four bytes
`timescale 1ns/100ps
`default_nettype none
`include "pin_irq_cfg.svh"
module pin_irq_ctrl
  import pin_irq_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // sources from fifo and data path
  input wire logic data_ready,
  input wire logic fifo_full,
  input wire logic [10:0] fifo_fill_bytes,
  // pin inputs, used as trigger when drivers are off
  input wire logic first_pin_in,
  input wire logic second_pin_in,
  // pin outputs, output enable low while driven
  output logic first_event_pin_out,
  output logic first_event_pin_oe_n,
  output logic second_event_pin_out,
  output logic second_event_pin_oe_n,
  // to power-mode trigger and fifo tagging
  output logic first_pin_trigger,
  output logic second_pin_trigger,
  output logic frame_tag_first_pin,
  output logic frame_tag_second_pin,
  // summary interrupt
  output logic irq
);
  typedef struct packed {
    logic [7:0] source_enable;
    logic [7:0] pin_output_control;
    logic [7:0] pin_input_control;
    logic [7:0] source_pin_routing;
    logic [7:0] watermark;
    logic [1:0] frame_tag_enable;
    logic [2:0] irq_status;
    logic [2:0] irq_enable;
    logic [2:0] src_prev;
    logic wr_pending;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic irq;
    logic first_trig;
    logic second_trig;
    logic first_tag;
    logic second_tag;
  } ctrl_state_t;
  ctrl_state_t state;
  ctrl_state_t next_state;
  logic [2:0] src_level;
  logic [2:0] src_enabled;
  logic [2:0] clear_bits;
  logic first_req;
  logic second_req;
  logic fwm_level;
  logic access;
  logic ext_first;
  logic ext_second;
  logic [7:0] wbyte;
  // watermark compares in four byte units, strictly greater
  assign fwm_level = (fifo_fill_bytes[10:`FILL_UNIT_SHIFT] >
                      {1'b0, state.watermark});
  assign src_level = {fwm_level, fifo_full, data_ready};
  assign src_enabled = src_level & {state.source_enable[`EN_FWM],
                                    state.source_enable[`EN_FFULL],
                                    state.source_enable[`EN_DRDY]};
  // an input-enabled pin carries the external interrupt, so routing is off
  assign ext_first = state.pin_input_control[`IC_P1_IN];
  assign ext_second = state.pin_input_control[`IC_P2_IN];
  // routing bits gate each source onto each pin
  always_comb begin
    first_req = (src_enabled[`ST_DRDY] &
                 state.source_pin_routing[`MAP_P1_DRDY]) |
                (src_enabled[`ST_FWM] &
                 state.source_pin_routing[`MAP_P1_FWM]) |
                (src_enabled[`ST_FFULL] &
                 state.source_pin_routing[`MAP_P1_FFULL]);
    second_req = (src_enabled[`ST_DRDY] &
                  state.source_pin_routing[`MAP_P2_DRDY]) |
                 (src_enabled[`ST_FWM] &
                  state.source_pin_routing[`MAP_P2_FWM]) |
                 (src_enabled[`ST_FFULL] &
                  state.source_pin_routing[`MAP_P2_FFULL]);
    if (ext_first | ext_second) begin
      first_req = 1'b0;
      second_req = 1'b0;
    end
  end
  assign access = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
  assign wbyte = hwdata[7:0];
  assign clear_bits = (state.wr_pending &&
                       state.wr_addr == `ADDR_IRQ_CLEAR) ?
                      hwdata[2:0] : 3'h0;
  // register file, status flags, pin side outputs
  always_comb begin
    next_state = state;
    next_state.src_prev = src_enabled;
    // sticky events: a new event in the clear cycle wins
    next_state.irq_status = (state.irq_status & ~clear_bits) |
                            (src_enabled & ~state.src_prev);
    // write data phase
    if (state.wr_pending) begin
      unique case (state.wr_addr)
        `ADDR_SOURCE_ENABLE:
          next_state.source_enable = wbyte & `MASK_SOURCE_ENABLE;
        `ADDR_PIN_OUTPUT_CONTROL:
          next_state.pin_output_control = wbyte;
        `ADDR_PIN_INPUT_CONTROL:
          next_state.pin_input_control = wbyte &
                                         `MASK_PIN_INPUT_CONTROL;
        `ADDR_SOURCE_PIN_ROUTING:
          next_state.source_pin_routing = wbyte & `MASK_ROUTING;
        `ADDR_IRQ_ENABLE:
          next_state.irq_enable = hwdata[2:0];
        `ADDR_WATERMARK:
          next_state.watermark = wbyte;
        `ADDR_FRAME_TAG:
          next_state.frame_tag_enable = hwdata[1:0];
        default: begin
        end
      endcase
    end
    next_state.wr_pending = access & hwrite;
    next_state.wr_addr = haddr;
    // read data registered from the address phase
    next_state.rdata = 32'h0;
    if (access && !hwrite) begin
      unique case (haddr)
        `ADDR_SOURCE_ENABLE:
          next_state.rdata = {24'h0, state.source_enable};
        `ADDR_PIN_OUTPUT_CONTROL:
          next_state.rdata = {24'h0, state.pin_output_control};
        `ADDR_PIN_INPUT_CONTROL:
          next_state.rdata = {24'h0, state.pin_input_control};
        `ADDR_SOURCE_PIN_ROUTING:
          next_state.rdata = {24'h0, state.source_pin_routing};
        `ADDR_IRQ_STATUS:
          next_state.rdata = {29'h0, state.irq_status};
        `ADDR_IRQ_ENABLE:
          next_state.rdata = {29'h0, state.irq_enable};
        `ADDR_WATERMARK:
          next_state.rdata = {24'h0, state.watermark};
        `ADDR_FRAME_TAG:
          next_state.rdata = {30'h0, state.frame_tag_enable};
        default:
          next_state.rdata = 32'h0;
      endcase
    end
    next_state.irq = |(state.irq_status & state.irq_enable);
    // trigger input honours polarity only while driver is off
    next_state.first_trig = ext_first &
                            ~state.pin_output_control[`OC_P1_DRIVE] &
                            (first_pin_in ~^
                             state.pin_output_control[`OC_P1_POL]);
    next_state.second_trig = ext_second &
                             ~state.pin_output_control[`OC_P2_DRIVE] &
                             (second_pin_in ~^
                              state.pin_output_control[`OC_P2_POL]);
    // tagging takes the raw pin level, polarity plays no part
    next_state.first_tag = state.frame_tag_enable[`TAG_P1] &
                           first_pin_in;
    next_state.second_tag = state.frame_tag_enable[`TAG_P2] &
                            second_pin_in;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
      state.watermark <= `RESET_WATERMARK;
    end else begin
      state <= next_state;
    end
  end
  // first pin stage
  pin_driver first_pin (
    .hclk(hclk),
    .hresetn(hresetn),
    .drive_enable(state.pin_output_control[`OC_P1_DRIVE]),
    .open_drain(state.pin_output_control[`OC_P1_OD]),
    .polarity(state.pin_output_control[`OC_P1_POL]),
    .edge_select(state.pin_output_control[`OC_P1_EDGE]),
    .request(first_req),
    .pin_out(first_event_pin_out),
    .pin_oe_n(first_event_pin_oe_n)
  );
  // second pin stage
  pin_driver second_pin (
    .hclk(hclk),
    .hresetn(hresetn),
    .drive_enable(state.pin_output_control[`OC_P2_DRIVE]),
    .open_drain(state.pin_output_control[`OC_P2_OD]),
    .polarity(state.pin_output_control[`OC_P2_POL]),
    .edge_select(state.pin_output_control[`OC_P2_EDGE]),
    .request(second_req),
    .pin_out(second_event_pin_out),
    .pin_oe_n(second_event_pin_oe_n)
  );
  // always zero wait state, always okay
  assign hrdata = state.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = state.irq;
  assign first_pin_trigger = state.first_trig;
  assign second_pin_trigger = state.second_trig;
  assign frame_tag_first_pin = state.first_tag;
  assign frame_tag_second_pin = state.second_tag;
endmodule // pin_irq_ctrl
`default_nettype wire

// ---- shared/pin_irq_cfg.svh ----
// register map, field positions and reset values of the pin interrupt block
// assumes it is included by bare name inside rtl and testbench files
`ifndef PIN_IRQ_CFG_SVH
`define PIN_IRQ_CFG_SVH
// register byte addresses (printed offsets are not all multiples of four)
`define IDX_SOURCE_ENABLE 8'h51
`define IDX_PIN_OUTPUT_CONTROL 8'h53
`define IDX_PIN_INPUT_CONTROL 8'h54
`define IDX_SOURCE_PIN_ROUTING 8'h56
`define ADDR_SOURCE_ENABLE 12'h144
`define ADDR_PIN_OUTPUT_CONTROL 12'h14C
`define ADDR_PIN_INPUT_CONTROL 12'h150
`define ADDR_SOURCE_PIN_ROUTING 12'h158
`define ADDR_IRQ_STATUS 12'h200
`define ADDR_IRQ_CLEAR 12'h204
`define ADDR_IRQ_ENABLE 12'h208
`define ADDR_WATERMARK 12'h20C
`define ADDR_FRAME_TAG 12'h210
// field positions
`define EN_FWM 6
`define EN_FFULL 5
`define EN_DRDY 4
`define OC_P2_DRIVE 7
`define OC_P2_OD 6
`define OC_P2_POL 5
`define OC_P2_EDGE 4
`define OC_P1_DRIVE 3
`define OC_P1_OD 2
`define OC_P1_POL 1
`define OC_P1_EDGE 0
`define IC_P2_IN 5
`define IC_P1_IN 4
`define MAP_P1_DRDY 7
`define MAP_P1_FWM 6
`define MAP_P1_FFULL 5
`define MAP_P2_DRDY 3
`define MAP_P2_FWM 2
`define MAP_P2_FFULL 1
`define ST_FWM 2
`define ST_FFULL 1
`define ST_DRDY 0
`define TAG_P1 1
`define TAG_P2 0
// writable masks and reset values
`define MASK_SOURCE_ENABLE 8'h70
`define MASK_PIN_INPUT_CONTROL 8'h30
`define MASK_ROUTING 8'hEE
`define MASK_STATUS 3'h7
`define RESET_BYTE 8'h00
`define RESET_WATERMARK 8'h80
`define FILL_UNIT_SHIFT 2
`define HTRANS_NONSEQ_BIT 1
`define ADDR_LSB 2
`endif

// ---- shared/pin_irq_pkg.sv ----
// types shared by the pin interrupt block
// assumes pin_irq_cfg.svh is on the include path
package pin_irq_pkg;
  // registered state of one interrupt pin stage
  typedef struct packed {
    logic active_prev;
    logic pulse;
    logic pin_level;
  } pin_stage_t;
endpackage

// ---- testbench/irq_line_host.sv ----
// host side of one interrupt line: pulled-up wire and active counter
// assumes pin signals change on hclk and the host drives only when free
`timescale 1ns/100ps
`default_nettype none
module irq_line_host (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin from the block and host drive
  input wire logic pin_out,
  input wire logic pin_oe_n,
  input wire logic host_drive,
  input wire logic host_level,
  input wire logic active_level,
  // resolved wire and cycles seen at the active level
  output logic line,
  output int active_cycles
);
  // pull-up wins when neither side drives, so open drain reads high
  assign line = !pin_oe_n ? pin_out : (host_drive ? host_level : 1'b1);
  // count active cycles so a pulse width can be judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) active_cycles <= 0;
    else if (line == active_level) active_cycles <= active_cycles + 1;
  end
endmodule // irq_line_host
`default_nettype wire

// ---- testbench/pin_irq_checker.sv ----
// checker of the pin interrupt block, watching its top ports only
// assumes word writes that land at the end of the data phase
`timescale 1ns/100ps
`default_nettype none
`include "pin_irq_cfg.svh"
module pin_irq_checker (
  // clock, reset and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // source and first pin
  input wire logic data_ready,
  input wire logic first_pin_in,
  input wire logic first_event_pin_out,
  input wire logic first_event_pin_oe_n,
  input wire logic first_pin_trigger,
  input wire logic frame_tag_first_pin
);
  logic wp, rp, pind;
  logic [11:0] wa;
  logic [7:0] en, oc, ic, mp, tg, ocd, icd, tgd;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // shadow registers rebuilt from bus writes; pins are judged against them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wp, rp, pind, wa, en, oc, ic, mp, tg, ocd, icd, tgd} <= '0;
    end else begin
      wp <= hsel && hready && htrans[1] && hwrite;
      rp <= hsel && hready && htrans[1] && !hwrite;
      wa <= haddr;
      {ocd, icd, tgd, pind} <= {oc, ic, tg, first_pin_in};
      if (wp) begin
        case (wa)
          `ADDR_SOURCE_ENABLE: en <= hwdata[7:0];
          `ADDR_PIN_OUTPUT_CONTROL: oc <= hwdata[7:0];
          `ADDR_PIN_INPUT_CONTROL: ic <= hwdata[7:0];
          `ADDR_SOURCE_PIN_ROUTING: mp <= hwdata[7:0];
          `ADDR_FRAME_TAG: tg <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_rdata_idle: assert property (!rp |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  a_push_pull: assert property (
    oc[3] && !oc[2] && ocd[3] && !ocd[2] |-> !first_event_pin_oe_n)
    else $error("push-pull pin not driven");
  a_open_drain: assert property (
    oc[3] && oc[2] && ocd[3] && ocd[2]
    |-> first_event_pin_oe_n == first_event_pin_out)
    else $error("open-drain pin drives high");
  a_trigger_in: assert property (
    first_pin_trigger == (icd[4] && !ocd[3] && pind == ocd[1]))
    else $error("trigger does not follow pin input");
  a_frame_tag: assert property (
    frame_tag_first_pin == (tgd[1] && pind))
    else $error("frame tag does not follow raw pin");
  a_level_follow: assert property (
    (oc[3] && !oc[0] && en[4] && mp[7] && ic[5:4] == 2'h0 && data_ready
    && $stable(oc)) [*3] |-> first_event_pin_out == oc[1])
    else $error("level pin not active for routed source");
  a_ext_cut: assert property (
    (oc[3] && ic[5:4] != 2'h0 && $stable(oc)) [*3]
    |-> first_event_pin_out == !oc[1])
    else $error("pin active while input mode cuts routing");
  a_edge_pulse: assert property (
    oc[3] && oc[0] && oc == ocd && first_event_pin_out == oc[1]
    |=> first_event_pin_out != oc[1] || $changed(oc))
    else $error("edge pulse longer than one cycle");
endmodule // pin_irq_checker
bind pin_irq_ctrl pin_irq_checker pin_irq_checker_i (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout,
  .hresp, .data_ready, .first_pin_in, .first_event_pin_out,
  .first_event_pin_oe_n, .first_pin_trigger, .frame_tag_first_pin);
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench of the pin interrupt block over ahb-lite
// assumes a host model on each pin and a 50 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "pin_irq_cfg.svh"
module tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, seed = 32'h4F2DE0F3, hrdata, rd;
  logic hreadyout, hresp, irq, o1, e1, o2, e2, t1, t2, g1, g2, l1, l2, x;
  logic data_ready = 0, fifo_full = 0, hd2 = 0, hv2 = 0;
  logic [10:0] fill = '0;
  logic [7:0] oc = '0;
  logic [11:0] ra [4] = '{`ADDR_SOURCE_ENABLE, `ADDR_PIN_OUTPUT_CONTROL,
    `ADDR_PIN_INPUT_CONTROL, `ADDR_SOURCE_PIN_ROUTING};
  logic [7:0] rm [4] = '{8'h70, 8'hFF, 8'h30, 8'hEE};
  logic [10:0] fv [3] = '{11'h00C, 11'h00F, 11'h010};
  int miscompares = 0, total_checks = 0, a1, a2, c1, c2, n;
  // 20 ns clock
  always #10 hclk = ~hclk;
  pin_irq_ctrl pin_irq_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .data_ready, .fifo_full, .fifo_fill_bytes(fill),
    .first_pin_in(l1), .second_pin_in(l2), .first_event_pin_out(o1),
    .first_event_pin_oe_n(e1), .second_event_pin_out(o2),
    .second_event_pin_oe_n(e2), .first_pin_trigger(t1),
    .second_pin_trigger(t2), .frame_tag_first_pin(g1),
    .frame_tag_second_pin(g2), .irq);
  irq_line_host h1 (.hclk, .hresetn, .pin_out(o1), .pin_oe_n(e1),
    .host_drive(1'b0), .host_level(1'b0), .active_level(oc[1]),
    .line(l1), .active_cycles(a1));
  irq_line_host h2 (.hclk, .hresetn, .pin_out(o2), .pin_oe_n(e2),
    .host_drive(hd2), .host_level(hv2), .active_level(oc[5]),
    .line(l2), .active_cycles(a2));
  // expected values come from these helpers, never from the design
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge hclk);
  endtask
  // bounded wait for hready; the slave is never assumed to be quick
  task automatic hwait();
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
  endtask
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  initial begin
    tick(4);
    hresetn <= 1'b1;
    tick(1);
    foreach (ra[i]) rc(ra[i], 32'h0);
    rc(`ADDR_WATERMARK, 32'h80);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      wr(ra[k % 4], seed);
      rc(ra[k % 4], {24'h0, seed[7:0] & rm[k % 4]});
    end
    wr(12'h3FC, seed);
    rc(12'h3FC, 32'h0);
    $display("test registers done");
    // drive, open drain and polarity of both pins, source on and off
    wr(ra[0], 32'h10);
    wr(ra[2], 32'h0);
    wr(ra[3], 32'h88);
    for (int k = 0; k < 16; k++) begin
      oc = {k[2:0], 1'b0, k[2:0], 1'b0};
      x = k[3] ~^ oc[1];
      wr(ra[1], {24'h0, oc});
      data_ready <= k[3];
      tick(3);
      chk1(e1, !oc[3] || (oc[2] && x));
      chk1(e2, !oc[7] || (oc[6] && x));
      if (oc[3]) chk1(o1, x);
      if (oc[7]) chk1(o2, x);
      chk1(l2, oc[7] ? x : 1'b1);
    end
    data_ready <= 1'b0;
    wr(ra[0], 32'h20);
    wr(ra[3], 32'h02);
    oc = 8'hAA;
    wr(ra[1], {24'h0, oc});
    fifo_full <= 1'b1;
    tick(3);
    chk1(o2, 1'b1);
    chk1(o1, 1'b0);
    wr(ra[0], 32'h0);
    tick(3);
    chk1(o2, 1'b0);
    $display("test pins done");
    // watermark boundary, then status, mask and clear of irq
    wr(ra[0], 32'h40);
    wr(ra[3], 32'h40);
    wr(`ADDR_WATERMARK, 32'h3);
    for (int k = 0; k < 3; k++) begin
      fill <= fv[k];
      tick(3);
      chk1(o1, k == 2);
    end
    wr(`ADDR_IRQ_CLEAR, 32'h7);
    fill <= 11'h0;
    tick(2);
    fill <= 11'h7FF;
    tick(3);
    rc(`ADDR_IRQ_STATUS, 32'h4);
    wr(`ADDR_IRQ_ENABLE, 32'h4);
    tick(2);
    chk1(irq, 1'b1);
    wr(`ADDR_IRQ_ENABLE, 32'h3);
    tick(2);
    chk1(irq, 1'b0);
    wr(`ADDR_IRQ_ENABLE, 32'h4);
    wr(`ADDR_IRQ_CLEAR, 32'h4);
    tick(2);
    chk1(irq, 1'b0);
    rc(`ADDR_IRQ_STATUS, 32'h0);
    $display("test watermark done");
    // edge mode gives one active cycle per source rise on each pin
    wr(ra[0], 32'h10);
    wr(ra[3], 32'h88);
    oc = 8'hBB;
    wr(ra[1], {24'h0, oc});
    tick(3);
    c1 = a1;
    c2 = a2;
    data_ready <= 1'b1;
    tick(6);
    chk(32'(a1 - c1), 32'h1);
    chk(32'(a2 - c2), 32'h1);
    $display("test edge done");
    // second pin as trigger input: polarity, frame tag, routing back once input is off
    oc = 8'h0A;
    wr(ra[1], {24'h0, oc});
    // no source may stay enabled while a pin carries the external interrupt
    wr(ra[0], 32'h0);
    wr(ra[2], 32'h20);
    hd2 <= 1'b1;
    hv2 <= 1'b0;
    tick(3);
    chk1(o1, 1'b0);
    chk1(t2, 1'b1);
    wr(`ADDR_FRAME_TAG, 32'h1);
    hv2 <= 1'b1;
    tick(3);
    chk1(t2, 1'b0);
    chk1(g2, 1'b1);
    oc = 8'h2A;
    wr(ra[1], {24'h0, oc});
    tick(3);
    chk1(t2, 1'b1);
    chk1(g2, 1'b1);
    wr(ra[2], 32'h0);
    wr(ra[0], 32'h10);
    tick(3);
    chk1(o1, 1'b1);
    $display("test input done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
